/* File: core/usbis_pkg.sv */
// Package of constants and types for the USB device interrupt status block
package usbis_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_CLEAR  = 4'h4;

	// Flag positions in the status and clear registers
	localparam int BIT_FRAME_START   = 2;
	localparam int BIT_BUS_RESET_END = 12;
	localparam int BIT_WAKEUP        = 13;
	localparam int BIT_EXT_RESUME    = 10;

	// Reset values of the flags; wake-up is cleared by software before use
	localparam logic RST_FLAG   = 1'b0;
	localparam logic RST_WAKEUP = 1'b0;

	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// Endpoint 0 readiness states
	typedef enum logic [1:0] {
		USBIS_EP0_IDLE  = 2'b00,
		USBIS_EP0_RESET = 2'b01,
		USBIS_EP0_READY = 2'b10
	} usbis_ep0_e;

	// Bus events presented to the flags
	typedef struct packed {
		logic ext_resume;
		logic frame_start;
		logic bus_reset_end;
		logic wakeup;
	} usbis_ev_s;

endpackage

/* File: core/usbis_flag.sv */
// One sticky status flag: set by an event, cleared by software
`timescale 1ns/1ps
module usbis_flag #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag
);
	logic next_flag;

	always_comb begin
		next_flag = flag;
		if (set) begin
			next_flag = 1'b1;  // see R07
		end else if (clr) begin
			next_flag = 1'b0;  // see R07
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag <= RST_VAL;
		end else begin
			flag <= next_flag;
		end
	end
endmodule // usbis_flag

/* File: core/usbis_top.sv */
// USB device port interrupt status flags with a small register port
//
// Operation
// R01: External resume flag reads 1 once raised, 0 while none pending.
// R02: Frame-start flag sets on each start-of-frame token detected.
// R03: Bus-reset-end flag sets when a bus reset sequence completes.
// R04: After bus reset end, endpoint 0 is ready for requests.
// R05: Wake-up flag sets on host resume or reset since last clear.
// R06: Software clears wake-up flag by writing one before relying on it.
// R07: Flags stay set until cleared by writing one; set beats clear.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module usbis_top (
	input  wire logic        REF_CLK,
	input  wire logic        NRST,
	input  wire logic [3:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        EXT_RESUME,
	input  wire logic        SOF_DETECTED,
	input  wire logic        BUS_RESET,
	input  wire logic        HOST_RESUME,
	output logic             EP0_READY
);
	usbis_pkg::usbis_ev_s   ev;
	usbis_pkg::usbis_ev_s   clr;
	usbis_pkg::usbis_ev_s   flags;
	usbis_pkg::usbis_ep0_e  ep0_state;
	usbis_pkg::usbis_ep0_e  next_ep0_state;
	logic                   bus_reset_d;
	logic                   next_bus_reset_d;
	logic [31:0]            next_rdata;
	logic                   wr_clear;

	function automatic logic [31:0] pack_flags(input usbis_pkg::usbis_ev_s f);
		logic [31:0] v;
		v = usbis_pkg::RD_ZERO;
		v[usbis_pkg::BIT_EXT_RESUME]    = f.ext_resume;
		v[usbis_pkg::BIT_FRAME_START]   = f.frame_start;
		v[usbis_pkg::BIT_BUS_RESET_END] = f.bus_reset_end;
		v[usbis_pkg::BIT_WAKEUP]        = f.wakeup;
		return v;
	endfunction

	function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	// End of bus reset is the falling edge of the reset indication
	always_comb begin
		next_bus_reset_d = BUS_RESET;
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			bus_reset_d <= 1'b0;
		end else begin
			bus_reset_d <= next_bus_reset_d;
		end
	end

	always_comb begin
		ev.ext_resume    = EXT_RESUME;                 // see R01
		ev.frame_start   = SOF_DETECTED;               // see R02
		ev.bus_reset_end = bus_reset_d && !BUS_RESET;  // see R03
		ev.wakeup        = HOST_RESUME || BUS_RESET;   // see R05
	end

	always_comb begin
		wr_clear = WR && addr_hit(ADDR, usbis_pkg::OFS_CLEAR);
		clr.ext_resume    = wr_clear && WDATA[usbis_pkg::BIT_EXT_RESUME];
		clr.frame_start   = wr_clear && WDATA[usbis_pkg::BIT_FRAME_START];
		clr.bus_reset_end = wr_clear && WDATA[usbis_pkg::BIT_BUS_RESET_END];
		clr.wakeup        = wr_clear && WDATA[usbis_pkg::BIT_WAKEUP];  // see R06
	end

	usbis_flag #(.RST_VAL(usbis_pkg::RST_FLAG)) u_ext_resume (
		.clk  (REF_CLK),
		.rst_n(NRST),
		.set  (ev.ext_resume),
		.clr  (clr.ext_resume),
		.flag (flags.ext_resume)
	);

	usbis_flag #(.RST_VAL(usbis_pkg::RST_FLAG)) u_frame_start (
		.clk  (REF_CLK),
		.rst_n(NRST),
		.set  (ev.frame_start),
		.clr  (clr.frame_start),
		.flag (flags.frame_start)
	);

	usbis_flag #(.RST_VAL(usbis_pkg::RST_FLAG)) u_bus_reset_end (
		.clk  (REF_CLK),
		.rst_n(NRST),
		.set  (ev.bus_reset_end),
		.clr  (clr.bus_reset_end),
		.flag (flags.bus_reset_end)
	);

	usbis_flag #(.RST_VAL(usbis_pkg::RST_WAKEUP)) u_wakeup (
		.clk  (REF_CLK),
		.rst_n(NRST),
		.set  (ev.wakeup),
		.clr  (clr.wakeup),
		.flag (flags.wakeup)
	);

	// Endpoint 0 readiness follows the bus reset sequence
	always_comb begin
		next_ep0_state = ep0_state;
		case (ep0_state)
			usbis_pkg::USBIS_EP0_IDLE: begin
				if (BUS_RESET) begin
					next_ep0_state = usbis_pkg::USBIS_EP0_RESET;
				end
			end
			usbis_pkg::USBIS_EP0_RESET: begin
				if (!BUS_RESET) begin
					next_ep0_state = usbis_pkg::USBIS_EP0_READY;  // see R04
				end
			end
			usbis_pkg::USBIS_EP0_READY: begin
				if (BUS_RESET) begin
					next_ep0_state = usbis_pkg::USBIS_EP0_RESET;
				end
			end
			default: begin
				next_ep0_state = usbis_pkg::USBIS_EP0_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ep0_state <= usbis_pkg::USBIS_EP0_IDLE;
		end else begin
			ep0_state <= next_ep0_state;
		end
	end

	// Read data stand only in the cycle after the read strobe
	always_comb begin
		next_rdata = usbis_pkg::RD_ZERO;
		if (RD) begin
			if (addr_hit(ADDR, usbis_pkg::OFS_STATUS)) begin
				next_rdata = pack_flags(flags);
			end else begin
				next_rdata = usbis_pkg::RD_ZERO;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= usbis_pkg::RD_ZERO;
		end else begin
			RDATA <= next_rdata;
		end
	end

	assign EP0_READY = (ep0_state == usbis_pkg::USBIS_EP0_READY);  // see R04

endmodule // usbis_top

/* File: bench/usbis_host.sv */
// Host and wake pin model: one bus event per requested code
`timescale 1ns/1ps
module usbis_host (
	input  wire logic       clk,
	input  wire logic [2:0] op,
	output logic            sof,
	output logic            brst,
	output logic            hres,
	output logic            xres
);
	initial {sof, brst, hres, xres} = 4'h0;
	always @(posedge clk) {sof, brst, hres, xres} <= {op == 3'h1, op == 3'h2, op == 3'h3, op == 3'h4};
endmodule // usbis_host

/* File: bench/usbis_chk.sv */
// Port assertions for the status flags
`timescale 1ns/1ps
module usbis_chk (
	input wire logic        REF_CLK,
	input wire logic        NRST,
	input wire logic [3:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        EXT_RESUME,
	input wire logic        SOF_DETECTED,
	input wire logic        BUS_RESET,
	input wire logic        HOST_RESUME,
	input wire logic        EP0_READY
);
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);
	wire logic rs = RD && ADDR == 4'h0;
	AST_EXT: assert property (rs && $past(EXT_RESUME) |=> RDATA[10]) else $error("resume");
	AST_SOF: assert property (rs && $past(SOF_DETECTED) |=> RDATA[2]) else $error("sof");
	AST_END: assert property (rs && $past(BUS_RESET, 3) && !$past(BUS_RESET, 2) && !$past(WR) |=> RDATA[12])
		else $error("reset end");
	AST_EP0: assert property ($fell(BUS_RESET) |=> EP0_READY) else $error("ep0");
	AST_WAKE: assert property (rs && $past(HOST_RESUME) |=> RDATA[13]) else $error("wakeup");
	AST_CLR: assert property (rs && $past(WR) && $past(ADDR) == 4'h4 && $past(WDATA[2]) && !$past(SOF_DETECTED)
		|=> !RDATA[2]) else $error("clear");
	AST_SET_WINS: assert property (rs && $past(WR) && $past(ADDR) == 4'h4
		&& $past(WDATA[2]) && $past(SOF_DETECTED) |=> RDATA[2]) else $error("set over clear");
	AST_EP0_BUSY: assert property (BUS_RESET |=> !EP0_READY) else $error("ep0 during reset");
endmodule // usbis_chk
bind usbis_top usbis_chk chk (
	.REF_CLK     (REF_CLK),
	.NRST        (NRST),
	.ADDR        (ADDR),
	.WDATA       (WDATA),
	.WR          (WR),
	.RD          (RD),
	.RDATA       (RDATA),
	.EXT_RESUME  (EXT_RESUME),
	.SOF_DETECTED(SOF_DETECTED),
	.BUS_RESET   (BUS_RESET),
	.HOST_RESUME (HOST_RESUME),
	.EP0_READY   (EP0_READY)
);

/* File: bench/test_usbis_top.sv */
// Random event bench for the status flags
`timescale 1ns/1ps
module test_usbis_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_q = 1'b0;
	logic        e0 = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] ex = 32'h0;
	logic [31:0] ex_q;
	logic [31:0] rdata;
	logic [2:0]  op = 3'h0;
	logic [2:0]  c;
	logic        sof, brst, hres, xres, ep0;
	// Flags that each host event code must raise
	function automatic logic [31:0] flag_mask(input logic [2:0] k);
		logic [31:0] m;
		m = 32'h0;
		case (k)
			3'h1: m[usbis_pkg::BIT_FRAME_START] = 1'b1;
			3'h2: begin
				m[usbis_pkg::BIT_BUS_RESET_END] = 1'b1;
				m[usbis_pkg::BIT_WAKEUP]        = 1'b1;
			end
			3'h3: m[usbis_pkg::BIT_WAKEUP] = 1'b1;
			3'h4: m[usbis_pkg::BIT_EXT_RESUME] = 1'b1;
			default: m = 32'h0;
		endcase
		return m;
	endfunction
	int          error_cnt = 0;
	int          checks = 0;
	usbis_host host (.clk(clk), .op(op), .sof(sof), .brst(brst), .hres(hres), .xres(xres));
	usbis_top dut (.REF_CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.EXT_RESUME(xres), .SOF_DETECTED(sof), .BUS_RESET(brst), .HOST_RESUME(hres), .EP0_READY(ep0));
	initial forever #10 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) {rd_q, ex_q} <= {rd, ex};
	always @(negedge clk) if (rd_q) chk("RDATA", ex_q, rdata);
	task automatic bus(input logic w, input logic [31:0] d);
		{wr, rd, addr, wdata, ex} <= {w, !w, w ? 4'h4 : 4'h0, d, d};
		@(posedge clk);
	endtask
	task automatic fire(input logic [2:0] k);
		{op, wr, rd} <= {k, 2'b0};
		repeat (k == 3'h2 ? 4 : 1) @(posedge clk);
		op <= 3'h0;
		repeat (k == 3'h2 ? 3 : 1) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h8846));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b1, 32'hffff_ffff);
		bus(1'b0, 32'h0);
		repeat (40) begin
			c = 3'($urandom_range(4, 1));
			fire(c);
			bus(1'b0, flag_mask(c));
			bus(1'b1, $urandom & ~flag_mask(c));
			bus(1'b0, flag_mask(c));
			bus(1'b1, flag_mask(c));
			bus(1'b0, 32'h0);
			e0 = e0 | (c == 3'h2);
			chk("EP0_READY", {31'h0, e0}, {31'h0, ep0});
		end
		// Clear and frame start on one edge: the event must win
		{op, wr, rd} <= {3'h1, 2'b0};
		@(posedge clk);
		op <= 3'h0;
		bus(1'b1, flag_mask(3'h1));
		bus(1'b0, flag_mask(3'h1));
		// Unmapped read returns zero while a flag is set
		{wr, rd, addr, ex} <= {1'b0, 1'b1, 4'h8, 32'h0};
		@(posedge clk);
		bus(1'b1, flag_mask(3'h1));
		bus(1'b0, 32'h0);
		// Let the last read be compared before the verdict
		{wr, rd} <= 2'b0;
		repeat (2) @(posedge clk);
		complete_run();
	end
endmodule // test_usbis_top
